/* File: logic/nv_access_ctrl.sv */
// data non-volatile store access controller with its register set
`timescale 1ns/10ps
`include "nv_access_regs.svh"
module nv_access_ctrl #(
  parameter int READ_CYCLES = `NV_READ_CYCLES,
  parameter int WRITE_TICKS = `NV_WRITE_TICKS
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // write timer source
  input wire logic sub_clk,
  // data memory port, address already resolved by the cpu
  input wire logic dm_bank,
  input wire logic [6:0] dm_addr,
  input wire logic dm_wr,
  input wire logic dm_rd,
  input wire logic [7:0] dm_wdata,
  output logic [7:0] dm_rdata,
  // event to interrupt logic
  output logic nv_write_done_flag
);
  localparam int DEPTH = 32;

  if (READ_CYCLES < 1 || READ_CYCLES > 16)
  begin : g_chk
    $error("nv_access_ctrl: READ_CYCLES out of range");
  end

  function automatic logic hit(input logic bank, input logic [6:0] addr,
                               input logic ref_bank,
                               input logic [6:0] ref_ofs);
    hit = (bank == ref_bank) && (addr == ref_ofs);
  endfunction

  function automatic logic [7:0] ctl_view(input logic rsv, input logic write_enable_bit,
                                          input logic wr, input logic read_enable_bit,
                                          input logic rd);
    ctl_view = {rsv, 3'b000, write_enable_bit, wr, read_enable_bit, rd};
  endfunction

  logic [4:0] addr_r, addr_nxt;
  logic [7:0] data_r, data_nxt;
  logic rsv_r, rsv_nxt;
  logic write_enable_bit_r, write_enable_bit_nxt;
  logic wr_r, wr_nxt;
  logic read_enable_bit_r, read_enable_bit_nxt;
  logic rd_r, rd_nxt;
  logic arm_r, arm_nxt;
  nv_access_pkg::nv_state_t state_r, state_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [4:0] cyc_addr_r, cyc_addr_nxt;
  logic [7:0] cyc_data_r, cyc_data_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic done_r, done_nxt;
  // 32 x 8 store, no reset: contents are non-volatile
  logic [7:0] mem [0:DEPTH-1];
  logic [7:0] mem_rd_q;
  logic mem_we;
  logic tmr_start;
  logic tmr_done;
  logic sel_adr, sel_dat, sel_ctl;
  logic wr_go, rd_go;

  assign dm_rdata = rdata_r;
  assign nv_write_done_flag = done_r;
  assign mem_rd_q = mem[cyc_addr_r];

  nv_write_timer #(
    .TICKS(WRITE_TICKS)
  ) u_tmr (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .sub_clk(sub_clk),
    .start(tmr_start),
    .done(tmr_done)
  );

  always_comb
  begin
    sel_adr = hit(dm_bank, dm_addr, `NV_DIR_BANK, `NV_ADR_OFS);
    sel_dat = hit(dm_bank, dm_addr, `NV_DIR_BANK, `NV_DAT_OFS);
    sel_ctl = hit(dm_bank, dm_addr, `NV_CTL_BANK, `NV_CTL_OFS);
    addr_nxt = addr_r;
    data_nxt = data_r;
    rsv_nxt = rsv_r;
    write_enable_bit_nxt = write_enable_bit_r;
    wr_nxt = wr_r;
    read_enable_bit_nxt = read_enable_bit_r;
    rd_nxt = rd_r;
    arm_nxt = 1'b0;
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    cyc_addr_nxt = cyc_addr_r;
    cyc_data_nxt = cyc_data_r;
    rdata_nxt = 8'h00;
    done_nxt = 1'b0;
    mem_we = 1'b0;
    tmr_start = 1'b0;
    wr_go = 1'b0;
    rd_go = 1'b0;
    if (dm_wr && sel_adr)
      addr_nxt = dm_wdata[4:0];
    if (dm_wr && sel_dat)
      data_nxt = dm_wdata;
    if (dm_wr && sel_ctl)
    begin
      rsv_nxt = dm_wdata[`NV_RSV_BIT];
      write_enable_bit_nxt = dm_wdata[`NV_WRITE_ENABLE_BIT_BIT];
      read_enable_bit_nxt = dm_wdata[`NV_READ_ENABLE_BIT_BIT];
      // enabling access opens a one-cycle window
      arm_nxt = dm_wdata[`NV_WRITE_ENABLE_BIT_BIT] && !dm_wdata[`NV_WR_BIT];
      if (state_r == nv_access_pkg::ST_IDLE)
      begin
        // write gated by prior enable and window
        wr_go = dm_wdata[`NV_WR_BIT] && dm_wdata[`NV_WRITE_ENABLE_BIT_BIT] &&
                write_enable_bit_r && arm_r;
        // write taken and read start dropped if both starts arrive
        rd_go = !wr_go && dm_wdata[`NV_RD_BIT] &&
                dm_wdata[`NV_READ_ENABLE_BIT_BIT] && read_enable_bit_r;
      end
    end
    case (state_r)
      nv_access_pkg::ST_IDLE:
      begin
        if (wr_go)
        begin
          state_nxt = nv_access_pkg::ST_WRITE;
          wr_nxt = 1'b1;
          cyc_addr_nxt = addr_r;
          cyc_data_nxt = data_r;
          tmr_start = 1'b1;
        end
        else if (rd_go)
        begin
          state_nxt = nv_access_pkg::ST_READ;
          rd_nxt = 1'b1;
          cnt_nxt = 4'(READ_CYCLES - 1);
          cyc_addr_nxt = addr_r;
        end
      end
      nv_access_pkg::ST_READ:
      begin
        // load byte and clear start together
        if (cnt_r == 4'h0)
        begin
          data_nxt = mem_rd_q;
          rd_nxt = 1'b0;
          state_nxt = nv_access_pkg::ST_IDLE;
        end
        else
          cnt_nxt = cnt_r - 4'h1;
      end
      nv_access_pkg::ST_WRITE:
      begin
        if (tmr_done)
        begin
          mem_we = 1'b1;
          wr_nxt = 1'b0;
          done_nxt = 1'b1;
          state_nxt = nv_access_pkg::ST_IDLE;
        end
      end
      default:
        state_nxt = nv_access_pkg::ST_IDLE;
    endcase
    if (dm_rd)
    begin
      if (sel_adr)
        rdata_nxt = {3'b000, addr_r};
      else if (sel_dat)
        rdata_nxt = data_r;
      else if (sel_ctl)
        rdata_nxt = ctl_view(rsv_r, write_enable_bit_r, wr_r, read_enable_bit_r, rd_r);
      else
        rdata_nxt = 8'h00;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      addr_r <= `NV_ADR_RST;
      data_r <= `NV_DAT_RST;
      rsv_r <= `NV_BIT_RST;
      write_enable_bit_r <= `NV_BIT_RST;
      wr_r <= `NV_BIT_RST;
      read_enable_bit_r <= `NV_BIT_RST;
      rd_r <= `NV_BIT_RST;
      arm_r <= 1'b0;
      state_r <= nv_access_pkg::ST_IDLE;
      cnt_r <= 4'h0;
      cyc_addr_r <= 5'h00;
      cyc_data_r <= 8'h00;
      rdata_r <= 8'h00;
      done_r <= 1'b0;
    end
    else
    begin
      addr_r <= addr_nxt;
      data_r <= data_nxt;
      rsv_r <= rsv_nxt;
      write_enable_bit_r <= write_enable_bit_nxt;
      wr_r <= wr_nxt;
      read_enable_bit_r <= read_enable_bit_nxt;
      rd_r <= rd_nxt;
      arm_r <= arm_nxt;
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      cyc_addr_r <= cyc_addr_nxt;
      cyc_data_r <= cyc_data_nxt;
      rdata_r <= rdata_nxt;
      done_r <= done_nxt;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (mem_we)
      mem[cyc_addr_r] <= cyc_data_r;
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  adr_read_a: assert property (
    dm_rd && sel_adr |=> rdata_r == {3'b000, $past(addr_r)})
    else $error("address readback wrong");

  ctl_rsv_a: assert property (
    dm_rd && sel_ctl |=> rdata_r[6:4] == 3'b000 && rdata_r[7] == $past(rsv_r))
    else $error("control reserved bits wrong");

  wr_gate_a: assert property (
    state_r == nv_access_pkg::ST_IDLE && !write_enable_bit_r
    |=> state_r != nv_access_pkg::ST_WRITE)
    else $error("write started without enable");

  wr_window_a: assert property (
    state_r == nv_access_pkg::ST_IDLE && !arm_r |=> !wr_r)
    else $error("write started outside window");

  wr_launch_a: assert property (
    state_r == nv_access_pkg::ST_IDLE && dm_wr && sel_ctl &&
    dm_wdata[`NV_WR_BIT] && dm_wdata[`NV_WRITE_ENABLE_BIT_BIT] && write_enable_bit_r && arm_r
    |=> wr_r && state_r == nv_access_pkg::ST_WRITE)
    else $error("write not launched");

  rd_gate_a: assert property (
    state_r == nv_access_pkg::ST_IDLE && !read_enable_bit_r
    |=> state_r != nv_access_pkg::ST_READ)
    else $error("read started without enable");

  rd_ignore_a: assert property (
    state_r == nv_access_pkg::ST_IDLE && dm_wr && sel_ctl &&
    dm_wdata[`NV_RD_BIT] && !read_enable_bit_r |=> !rd_r)
    else $error("read start not ignored");

  rd_bound_a: assert property (
    $rose(rd_r) |-> ##[1:16] !rd_r)
    else $error("read cycle hung");

  rd_data_a: assert property (
    $fell(rd_r) |-> data_r == $past(mem_rd_q))
    else $error("read data wrong");

  wr_end_a: assert property (
    state_r == nv_access_pkg::ST_WRITE && tmr_done
    |=> !wr_r && nv_write_done_flag ##1 !nv_write_done_flag)
    else $error("write completion wrong");

  done_src_a: assert property (
    nv_write_done_flag |-> $past(state_r) == nv_access_pkg::ST_WRITE && !wr_r)
    else $error("done without a write cycle");

  data_hold_a: assert property (
    state_r == nv_access_pkg::ST_IDLE && !(dm_wr && sel_dat)
    |=> $stable(data_r))
    else $error("data register changed");

  wr_cover_c: cover property ($fell(wr_r));
  rd_cover_c: cover property ($fell(rd_r));
  refuse_cover_c: cover property (
    dm_wr && sel_ctl && dm_wdata[`NV_WR_BIT] && !write_enable_bit_r);
  late_cover_c: cover property (
    dm_wr && sel_ctl && dm_wdata[`NV_WR_BIT] && write_enable_bit_r && !arm_r);
endmodule

/* File: logic/nv_access_regs.svh */
// constants of the data non-volatile store access controller
// Operation
// - store holds 32 bytes, one byte per access, outside normal memory
// - address register: 5-bit index, bits 7..5 read zero, resets zero
// - data register: full 8-bit read/write, resets zero
// - address and data in bank 0; control at 40H of bank 1
// - write enable low refuses every write cycle
// - setting write start launches a write of data register to address
// - hardware clears write start when the write cycle completes
// - write start without write enable already set does nothing
// - read enable low refuses every read cycle
// - setting read start launches a read of the addressed byte
// - hardware clears read start once data register holds read byte
// - read start without read enable already set is ignored
// - control bit 7 reserved read/write zero; bits 6..4 read zero
// - write start must follow the enabling access directly
// - write duration timed by a timer asynchronous to system clock
// - each completed write raises the write done request
// - read data stays in data register until next read or write
`ifndef NV_ACCESS_REGS_SVH
`define NV_ACCESS_REGS_SVH
`define NV_DIR_BANK 1'b0
`define NV_CTL_BANK 1'b1
`define NV_ADR_OFS 7'h40
`define NV_DAT_OFS 7'h41
`define NV_CTL_OFS 7'h40
`define NV_RD_BIT 0
`define NV_READ_ENABLE_BIT_BIT 1
`define NV_WR_BIT 2
`define NV_WRITE_ENABLE_BIT_BIT 3
`define NV_RSV_BIT 7
`define NV_ADR_RST 5'h00
`define NV_DAT_RST 8'h00
`define NV_BIT_RST 1'b0
`define NV_READ_CYCLES 2
`define NV_WRITE_TICKS 8
`endif

/* File: logic/nv_access_pkg.sv */
// types of the data non-volatile store access controller
package nv_access_pkg;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_READ,
    ST_WRITE
  } nv_state_t;
endpackage

/* File: logic/nv_write_timer.sv */
// write-cycle timer counting sub clock ticks
`timescale 1ns/10ps
`include "nv_access_regs.svh"
module nv_write_timer #(
  parameter int TICKS = `NV_WRITE_TICKS
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // slow timer source, asynchronous
  input wire logic sub_clk,
  // control
  input wire logic start,
  output logic done
);
  localparam int CW = $clog2(TICKS + 1);

  if (TICKS < 1 || TICKS > 65535)
  begin : g_chk
    $error("nv_write_timer: TICKS out of range");
  end

  logic sub_s1_r;
  logic sub_s2_r;
  logic sub_s3_r;
  logic tick;
  logic busy_r, busy_nxt;
  logic done_r, done_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;

  assign done = done_r;

  // rising sub clock edges, seen after the two-stage synchroniser
  always_comb
  begin
    tick = sub_s2_r & ~sub_s3_r;
    busy_nxt = busy_r;
    cnt_nxt = cnt_r;
    done_nxt = 1'b0;
    if (start)
    begin
      busy_nxt = 1'b1;
      cnt_nxt = CW'(TICKS);
    end
    else if (busy_r && tick)
    begin
      cnt_nxt = cnt_r - CW'(1);
      if (cnt_r == CW'(1))
      begin
        busy_nxt = 1'b0;
        done_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sub_s1_r <= 1'b0;
      sub_s2_r <= 1'b0;
      sub_s3_r <= 1'b0;
      busy_r <= 1'b0;
      cnt_r <= '0;
      done_r <= 1'b0;
    end
    else
    begin
      sub_s1_r <= sub_clk;
      sub_s2_r <= sub_s1_r;
      sub_s3_r <= sub_s2_r;
      busy_r <= busy_nxt;
      cnt_r <= cnt_nxt;
      done_r <= done_nxt;
    end
  end
endmodule

/* File: sim/testbench.sv */
// self-checking bench for the store access controller
`timescale 1ns/10ps
`include "nv_access_regs.svh"
`define CHECK(got, exp) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) \
    begin \
      err_count++; \
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp); \
    end \
  end
module testbench;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic sub_clk = 1'b0;
  logic dm_bank = 1'b0;
  logic [6:0] dm_addr = 7'h00;
  logic dm_wr = 1'b0;
  logic dm_rd = 1'b0;
  logic [7:0] dm_wdata = 8'h00;
  logic [7:0] dm_rdata;
  logic nv_write_done_flag;
  logic [7:0] rv;
  int err_count = 0;
  int tests_run = 0;
  int done_cnt = 0;

  nv_access_ctrl i_dut (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .sub_clk(sub_clk),
    .dm_bank(dm_bank),
    .dm_addr(dm_addr),
    .dm_wr(dm_wr),
    .dm_rd(dm_rd),
    .dm_wdata(dm_wdata),
    .dm_rdata(dm_rdata),
    .nv_write_done_flag(nv_write_done_flag)
  );

  always #2 sys_clk = ~sys_clk;
  // sub clock runs from time zero, unrelated to sys_clk
  always #12 sub_clk = ~sub_clk;

  always @(posedge sys_clk)
    if (nv_write_done_flag === 1'b1)
      done_cnt++;

  task automatic close_out;
    $display("compares %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic gap;
    @(posedge sys_clk);
    #1;
  endtask

  // one write access; last high drops the strobe and lets an edge pass
  task automatic wr_reg(input logic b, input logic [6:0] a,
                        input logic [7:0] d, input bit last);
    dm_bank = b;
    dm_addr = a;
    dm_wdata = d;
    dm_wr = 1'b1;
    gap();
    if (last)
    begin
      dm_wr = 1'b0;
      gap();
    end
  endtask

  task automatic rd_reg(input logic b, input logic [6:0] a);
    dm_bank = b;
    dm_addr = a;
    dm_rd = 1'b1;
    gap();
    dm_rd = 1'b0;
    rv = dm_rdata;
    gap();
  endtask

  task automatic ctl(input logic [7:0] d, input bit last);
    wr_reg(`NV_CTL_BANK, `NV_CTL_OFS, d, last);
  endtask

  task automatic t_reset;
    rd_reg(`NV_DIR_BANK, `NV_ADR_OFS);
    `CHECK(rv, 8'h00)
    rd_reg(`NV_DIR_BANK, `NV_DAT_OFS);
    `CHECK(rv, 8'h00)
    rd_reg(`NV_CTL_BANK, `NV_CTL_OFS);
    `CHECK(rv, 8'h00)
  endtask

  task automatic t_regs;
    wr_reg(`NV_DIR_BANK, `NV_ADR_OFS, 8'hFF, 1'b1);
    rd_reg(`NV_DIR_BANK, `NV_ADR_OFS);
    `CHECK(rv, 8'h1F)
    rd_reg(`NV_CTL_BANK, `NV_CTL_OFS);
    `CHECK(rv, 8'h00)
    wr_reg(`NV_DIR_BANK, `NV_DAT_OFS, 8'hA5, 1'b1);
    rd_reg(`NV_DIR_BANK, `NV_DAT_OFS);
    `CHECK(rv, 8'hA5)
    rd_reg(`NV_CTL_BANK, `NV_DAT_OFS);
    `CHECK(rv, 8'h00)
    ctl(8'h70, 1'b1);
    rd_reg(`NV_CTL_BANK, `NV_CTL_OFS);
    `CHECK(rv, 8'h00)
    ctl(8'h00, 1'b1);
    rd_reg(`NV_CTL_BANK, `NV_CTL_OFS);
    `CHECK(rv, 8'h00)
  endtask

  task automatic t_write(input logic [7:0] a, input logic [7:0] d);
    int n0;
    int i;
    n0 = done_cnt;
    wr_reg(`NV_DIR_BANK, `NV_ADR_OFS, a, 1'b1);
    wr_reg(`NV_DIR_BANK, `NV_DAT_OFS, d, 1'b1);
    // enable then start on the very next clock
    ctl(8'h08, 1'b0);
    ctl(8'h0C, 1'b1);
    rd_reg(`NV_CTL_BANK, `NV_CTL_OFS);
    `CHECK(rv, 8'h0C)
    for (i = 0; i < 100 && rv[`NV_WR_BIT] !== 1'b0; i++)
      rd_reg(`NV_CTL_BANK, `NV_CTL_OFS);
    `CHECK(rv, 8'h08)
    `CHECK(done_cnt - n0, 1)
    ctl(8'h00, 1'b1);
  endtask

  task automatic t_refuse;
    int n0;
    n0 = done_cnt;
    wr_reg(`NV_DIR_BANK, `NV_ADR_OFS, 8'h00, 1'b1);
    wr_reg(`NV_DIR_BANK, `NV_DAT_OFS, 8'hFF, 1'b1);
    ctl(8'h04, 1'b1);
    rd_reg(`NV_CTL_BANK, `NV_CTL_OFS);
    `CHECK(rv, 8'h00)
    ctl(8'h08, 1'b1);
    gap();
    ctl(8'h0C, 1'b1);
    rd_reg(`NV_CTL_BANK, `NV_CTL_OFS);
    `CHECK(rv, 8'h08)
    ctl(8'h01, 1'b1);
    rd_reg(`NV_CTL_BANK, `NV_CTL_OFS);
    `CHECK(rv, 8'h00)
    repeat (60) gap();
    rd_reg(`NV_DIR_BANK, `NV_DAT_OFS);
    `CHECK(rv, 8'hFF)
    `CHECK(done_cnt - n0, 0)
  endtask

  task automatic t_read(input logic [7:0] a, input logic [7:0] exp);
    int i;
    wr_reg(`NV_DIR_BANK, `NV_ADR_OFS, a, 1'b1);
    ctl(8'h02, 1'b0);
    ctl(8'h03, 1'b1);
    rd_reg(`NV_CTL_BANK, `NV_CTL_OFS);
    for (i = 0; i < 40 && rv[`NV_RD_BIT] !== 1'b0; i++)
      rd_reg(`NV_CTL_BANK, `NV_CTL_OFS);
    `CHECK(rv, 8'h02)
    rd_reg(`NV_DIR_BANK, `NV_DAT_OFS);
    `CHECK(rv, exp)
    repeat (20) gap();
    rd_reg(`NV_DIR_BANK, `NV_DAT_OFS);
    `CHECK(rv, exp)
    ctl(8'h00, 1'b1);
  endtask

  initial
  begin
    repeat (5) @(posedge sys_clk);
    #1;
    rst_b = 1'b1;
    t_reset();
    t_regs();
    t_write(8'h00, 8'h5A);
    t_write(8'h1F, 8'hC3);
    t_refuse();
    rst_b = 1'b0;
    repeat (2) gap();
    rst_b = 1'b1;
    t_reset();
    t_read(8'h00, 8'h5A);
    t_read(8'h1F, 8'hC3);
    close_out();
  end

  initial
  begin
    #40000;
    err_count++;
    close_out();
  end
endmodule
